// ---- pkg/ai_scan_defines.svh ----
// Constants shared by the analog scan device and its processor end
// How it works
// - Sequential read steps point, starts next cycle
// - Cycle selects, converts, then raises interrupt
// - Read without step bit ends sequential operation
// - Initialize-read points at count and scan table
// - Each store decrements count, steps pointer and, outside random mode, point address
// - Start steals count load, then mux load
// - Conversion end steals cycle, stores at pointer
// - Count zero checks scan bits; 11 chains
// - Chaining takes four stolen cycles in order
// - Pattern 00 stops and interrupts; command restarts
// - Random mode uses two channels, two commands
// - Random mode alternates fetch and store cycles
// - Software sizes mux table to count
// - Initialize-read bit 10 selects random mode
// - Overlap: only solid-state points stored in random mode
// - Accept area codes 01010 and 10000 only
// - Resolution bits select 8, 11, 14 bits
// - Modifier bits select sync, reset, step, random
// - Chain bit chains; clear interrupt bit interrupts
// - Result word carries sign and overload bits
// - Mux word: compare, limit, type, point fields
// - Sense bit 8 picks mux point address or unit status
// - Sense with bit 15 set and bit 8 clear clears unit status
// - End-of-table indicator sets and interrupts
`ifndef AI_SCAN_DEFINES_SVH
`define AI_SCAN_DEFINES_SVH
// Area codes
`define AREA_BASIC   5'h0a
`define AREA_EXPAND  5'h10
// Command functions
`define FN_WRITE     3'h1
`define FN_READ      3'h2
`define FN_SENSE     3'h3
`define FN_INIT_RD   3'h4
`define FN_INIT_WR   3'h5
`define FN_CONTROL   3'h6
// Modifier bit positions, index 0 is command bit 8
`define MB_BIT8      0
`define MB_LOW       1
`define MB_RAND      2
`define MB_HIGH      3
`define MB_RESET     7
// Table control word
`define TW_CHAIN     15
`define TW_NOINT     14
`define TW_CNT_W     14
// Multiplexer address word
`define MW_LIMIT     14
`define MW_CMP       13
`define MW_SS        12
`define MW_PT_W      11
// Result word
`define RW_SIGN      15
`define RW_OVER      14
// Unit status word
`define SW_EOT       15
`define SW_SS_DONE   14
`define SW_RLY_DONE  13
`define SW_CHK_ERR   12
`define SW_OVERLOAD  11
`define SW_BUSY      0
// Resolution masks on the 14-bit magnitude
`define MASK_LOW     14'h3fc0
`define MASK_MID     14'h3ff8
// Host register offsets
`define OFF_CMD      12'h000
`define OFF_STAT     12'h004
`define OFF_MADDR    12'h008
`define OFF_MDATA    12'h00c
// Host storage
`define MEM_AW       8
`define MEM_DEPTH    256
`endif

// ---- pkg/ai_scan_pkg.sv ----
// Types for the analog scan device and its processor end
package ai_scan_pkg;
  typedef enum logic [10:0] {
    ST_IDLE     = 11'h001,
    ST_LOAD_WC  = 11'h002,
    ST_LOAD_MUX = 11'h004,
    ST_SELECT   = 11'h008,
    ST_CONV     = 11'h010,
    ST_DPC_HOLD = 11'h020,
    ST_STORE    = 11'h040,
    ST_CHAIN_CA = 11'h080,
    ST_CHAIN_CK = 11'h100,
    ST_WAIT_MUX = 11'h200,
    ST_FETCH    = 11'h400
  } scan_state_t;
  typedef logic [15:0] word_t;
endpackage

// ---- pkg/ai_link_if.sv ----
// Link between processor end and analog scan device
`timescale 1ns/1ps
interface ai_link_if;
  // Command path
  logic        cmd_valid;
  logic        cmd_ready;
  logic [4:0]  cmd_area;
  logic [2:0]  cmd_func;
  logic [7:0]  cmd_mod;
  logic [15:0] cmd_word;
  // Answer to read and sense
  logic        resp_valid;
  logic [15:0] resp_data;
  // Cycle steal channels
  logic        cs_req;
  logic        cs_we;
  logic        cs_chan;
  logic [15:0] cs_addr;
  logic [15:0] cs_wdata;
  logic        cs_ack;
  logic [15:0] cs_rdata;
  // Interrupt level
  logic        irq;
  modport dev (input cmd_valid, cmd_area, cmd_func, cmd_mod, cmd_word,
               output cmd_ready, resp_valid, resp_data,
               output cs_req, cs_we, cs_chan, cs_addr, cs_wdata,
               input cs_ack, cs_rdata, output irq);
  modport pc (output cmd_valid, cmd_area, cmd_func, cmd_mod, cmd_word,
              input cmd_ready, resp_valid, resp_data,
              input cs_req, cs_we, cs_chan, cs_addr, cs_wdata,
              output cs_ack, cs_rdata, input irq);
endinterface

// ---- hdl/ai_pc_host.sv ----
// Processor end: APB command registers, storage, cycle steal grant
`timescale 1ns/1ps
`include "ai_scan_defines.svh"
module ai_pc_host (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RESET_N,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Device link
  ai_link_if.pc                  LINK
);
  import ai_scan_pkg::*;

  logic [15:0]          mem [0:`MEM_DEPTH-1];
  logic                 pend_r;
  logic [31:0]          cmd_r;
  logic [15:0]          resp_r;
  logic [`MEM_AW-1:0]   maddr_r;
  logic [31:0]          prdata_r;
  logic                 ack_r;
  logic [15:0]          csr_r;
  logic                 acc;
  logic                 mapped;
  logic                 mem_wr;

  assign acc    = PSEL && PENABLE;
  assign mapped = (PADDR == `OFF_CMD) || (PADDR == `OFF_STAT) ||
                  (PADDR == `OFF_MADDR) || (PADDR == `OFF_MDATA);
  assign mem_wr = acc && PWRITE && (PADDR == `OFF_MDATA);
  // Slave always answers in the first access cycle
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !mapped;
  assign PRDATA  = prdata_r;

  // Command word; a second write while pending is dropped
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      pend_r <= 1'b0;
      cmd_r  <= 32'h0000_0000;
    end else if (acc && PWRITE && PADDR == `OFF_CMD && !pend_r) begin
      pend_r <= 1'b1;
      cmd_r  <= PWDATA;
    end else if (LINK.cmd_valid && LINK.cmd_ready) begin
      pend_r <= 1'b0;
    end
  end
  assign LINK.cmd_valid = pend_r;
  assign LINK.cmd_word  = cmd_r[15:0];
  assign LINK.cmd_area  = cmd_r[20:16];
  assign LINK.cmd_func  = cmd_r[23:21];
  assign LINK.cmd_mod   = cmd_r[31:24];

  // Latest answer from the device
  always_ff @(posedge MCLK) begin
    if (!RESET_N)
      resp_r <= 16'h0000;
    else if (LINK.resp_valid)
      resp_r <= LINK.resp_data;
  end

  // Storage address pointer for software access
  always_ff @(posedge MCLK) begin
    if (!RESET_N)
      maddr_r <= '0;
    else if (acc && PWRITE && PADDR == `OFF_MADDR)
      maddr_r <= PWDATA[`MEM_AW-1:0];
  end

  // Read data captured in the setup cycle
  always_ff @(posedge MCLK) begin
    if (!RESET_N)
      prdata_r <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        `OFF_CMD:   prdata_r <= cmd_r;
        `OFF_STAT:  prdata_r <= {resp_r, 14'h0000, LINK.irq, pend_r};
        `OFF_MADDR: prdata_r <= {24'h000000, maddr_r};
        `OFF_MDATA: prdata_r <= {16'h0000, mem[maddr_r]};
        default:    prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Cycle steal grant; software storage write takes the slot first
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ack_r <= 1'b0;
      csr_r <= 16'h0000;
    end else begin
      ack_r <= LINK.cs_req && !ack_r && !mem_wr;
      csr_r <= mem[LINK.cs_addr[`MEM_AW-1:0]];
    end
  end
  assign LINK.cs_ack   = ack_r;
  assign LINK.cs_rdata = csr_r;

  // Storage array, one writer
  always_ff @(posedge MCLK) begin
    if (mem_wr)
      mem[maddr_r] <= PWDATA[15:0];
    else if (LINK.cs_req && !ack_r && LINK.cs_we)
      mem[LINK.cs_addr[`MEM_AW-1:0]] <= LINK.cs_wdata;
  end
endmodule

// ---- hdl/ai_scan_dev.sv ----
// Analog input scan control: command decode, sequencing, cycle steals
`timescale 1ns/1ps
`include "ai_scan_defines.svh"
module ai_scan_dev (
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RESET_N,
  // Processor link
  ai_link_if.dev                 LINK,
  // Multiplexer and converter
  output logic [`MW_PT_W-1:0]    MUX_POINT,
  output logic                   MUX_SS,
  output logic                   CONV_START,
  output logic [1:0]             CONV_RES,
  input  wire logic              SYNC_IN,
  input  wire logic              CONV_DONE,
  input  wire logic              CONV_SIGN,
  input  wire logic [13:0]       CONV_MAG,
  input  wire logic              CONV_OVER
);
  import ai_scan_pkg::*;

  scan_state_t          st_r;
  scan_state_t          st_nxt;
  ai_scan_pkg::word_t   channel_pointer_reg;
  ai_scan_pkg::word_t   mux_chan_ptr_r;
  ai_scan_pkg::word_t   mux_point_address_reg;
  ai_scan_pkg::word_t   result_r;
  logic [`TW_CNT_W-1:0] transfer_count_reg;
  logic [1:0]           scan_action_reg;
  logic                 rand_r;
  logic                 ext_r;
  logic                 mux_go_r;
  logic [1:0]           res_r;
  logic                 eot_r;
  logic                 ss_done_r;
  logic                 rly_done_r;
  logic                 chk_err_r;
  logic                 over_r;
  logic                 resp_v_r;
  logic [15:0]          resp_d_r;
  logic                 start_r;
  logic                 area_ok;
  logic                 take;
  logic                 table_end;
  logic                 clr_stat;
  logic [13:0]          mag_masked;
  logic [15:0]          stat_word;

  // Both the basic and the expander area are served here
  assign area_ok = (LINK.cmd_area == `AREA_BASIC) ||
                   (LINK.cmd_area == `AREA_EXPAND);
  // Sense and control are never held off by a running scan
  assign LINK.cmd_ready = area_ok && ((st_r == ST_IDLE) ||
      (LINK.cmd_func == `FN_SENSE) || (LINK.cmd_func == `FN_CONTROL) ||
      (st_r == ST_WAIT_MUX && LINK.cmd_func == `FN_INIT_WR) ||
      (st_r == ST_DPC_HOLD && LINK.cmd_func == `FN_READ));
  assign take = LINK.cmd_valid && LINK.cmd_ready;
  assign table_end = (st_r == ST_STORE) && LINK.cs_ack &&
                     (transfer_count_reg == `TW_CNT_W'(1));
  assign clr_stat = take && LINK.cmd_func == `FN_SENSE &&
                    !LINK.cmd_mod[`MB_BIT8] &&
                    LINK.cmd_mod[`MB_RESET];

  // Cycle steal request is held until the grant arrives
  assign LINK.cs_req = (st_r == ST_STORE) || (st_r == ST_CHAIN_CA) ||
                       (st_r == ST_CHAIN_CK) || (st_r == ST_LOAD_WC) ||
                       (st_r == ST_LOAD_MUX) || (st_r == ST_FETCH);
  assign LINK.cs_we    = (st_r == ST_STORE);
  assign LINK.cs_chan  = (st_r == ST_FETCH);
  assign LINK.cs_addr  = (st_r == ST_FETCH) ? mux_chan_ptr_r
                                            : channel_pointer_reg;
  assign LINK.cs_wdata = result_r;

  // Point select and converter controls
  assign MUX_POINT  = mux_point_address_reg[`MW_PT_W-1:0];
  assign MUX_SS     = mux_point_address_reg[`MW_SS];
  assign CONV_START = start_r;
  assign CONV_RES   = res_r;
  assign LINK.resp_valid = resp_v_r;
  assign LINK.resp_data  = resp_d_r;
  assign LINK.irq = eot_r || ss_done_r || rly_done_r || chk_err_r ||
                    over_r;

  // Truncate magnitude to the selected resolution
  always_comb begin
    if (res_r[1])
      mag_masked = CONV_MAG;
    else if (res_r[0])
      mag_masked = CONV_MAG & `MASK_LOW;
    else
      mag_masked = CONV_MAG & `MASK_MID;
  end

  always_comb begin
    stat_word = 16'h0000;
    stat_word[`SW_EOT]      = eot_r;
    stat_word[`SW_SS_DONE]  = ss_done_r;
    stat_word[`SW_RLY_DONE] = rly_done_r;
    stat_word[`SW_CHK_ERR]  = chk_err_r;
    stat_word[`SW_OVERLOAD] = over_r;
    stat_word[`SW_BUSY]     = (st_r != ST_IDLE);
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (take && LINK.cmd_func == `FN_WRITE)
          st_nxt = ST_SELECT;
        else if (take && LINK.cmd_func == `FN_INIT_RD)
          st_nxt = ST_LOAD_WC;
      end
      ST_LOAD_WC: begin
        if (LINK.cs_ack)
          st_nxt = !rand_r ? ST_LOAD_MUX :
                   (mux_go_r ? ST_FETCH : ST_WAIT_MUX);
      end
      ST_LOAD_MUX: if (LINK.cs_ack) st_nxt = ST_SELECT;
      ST_WAIT_MUX: begin
        if (take && LINK.cmd_func == `FN_INIT_WR)
          st_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        // Relay entries are read by program, never stored here
        if (LINK.cs_ack && LINK.cs_rdata[`MW_SS])
          st_nxt = ST_SELECT;
      end
      ST_SELECT: if (!ext_r || SYNC_IN) st_nxt = ST_CONV;
      ST_CONV: if (CONV_DONE) st_nxt = ST_STORE;
      ST_DPC_HOLD: begin
        if (take && LINK.cmd_func == `FN_READ)
          st_nxt = LINK.cmd_mod[`MB_BIT8] ? ST_SELECT
                                          : ST_IDLE;
      end
      ST_STORE: begin
        if (table_end)
          st_nxt = scan_action_reg[1] ? ST_CHAIN_CA : ST_IDLE;
        else if (LINK.cs_ack)
          st_nxt = rand_r ? ST_FETCH : ST_SELECT;
      end
      ST_CHAIN_CA: if (LINK.cs_ack) st_nxt = ST_CHAIN_CK;
      ST_CHAIN_CK: begin
        if (LINK.cs_ack)
          st_nxt = (LINK.cs_rdata == channel_pointer_reg) ?
                   ST_LOAD_WC : ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Program mode waits for the read instead of stealing a cycle
    if (st_r == ST_CONV && CONV_DONE && !mux_go_r && scan_action_reg == 2'b00
        && transfer_count_reg == '0 && !rand_r)
      st_nxt = ST_DPC_HOLD;
    if (take && LINK.cmd_func == `FN_CONTROL)
      st_nxt = ST_IDLE;
  end

  // State register
  always_ff @(posedge MCLK) begin
    if (!RESET_N)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  // Mode bits taken from commands
  always_ff @(posedge MCLK) begin
    if (!RESET_N || (take && LINK.cmd_func == `FN_CONTROL)) begin
      rand_r   <= 1'b0;
      ext_r    <= 1'b0;
      mux_go_r <= 1'b0;
      res_r    <= 2'b00;
    end else if (take && (LINK.cmd_func == `FN_WRITE ||
                          LINK.cmd_func == `FN_INIT_RD)) begin
      ext_r    <= LINK.cmd_mod[`MB_BIT8];
      res_r    <= {LINK.cmd_mod[`MB_HIGH], LINK.cmd_mod[`MB_LOW]};
      rand_r   <= (LINK.cmd_func == `FN_INIT_RD) &&
                  LINK.cmd_mod[`MB_RAND];
      mux_go_r <= 1'b0;
    end else if (take && LINK.cmd_func == `FN_INIT_WR) begin
      mux_go_r <= 1'b1;
    end
  end

  // Pointers, count and point address
  always_ff @(posedge MCLK) begin
    if (!RESET_N || (take && LINK.cmd_func == `FN_CONTROL)) begin
      channel_pointer_reg   <= 16'h0000;
      mux_chan_ptr_r        <= 16'h0000;
      mux_point_address_reg <= 16'h0000;
      transfer_count_reg    <= '0;
      scan_action_reg       <= 2'b00;
    end else begin
      if (take && LINK.cmd_func == `FN_WRITE) begin
        mux_point_address_reg <= LINK.cmd_word;
        transfer_count_reg    <= '0;
        scan_action_reg       <= 2'b00;
      end
      if (take && LINK.cmd_func == `FN_INIT_RD)
        channel_pointer_reg <= LINK.cmd_word;
      if (take && LINK.cmd_func == `FN_INIT_WR)
        mux_chan_ptr_r <= LINK.cmd_word;
      if (take && LINK.cmd_func == `FN_READ && st_r == ST_DPC_HOLD &&
          LINK.cmd_mod[`MB_BIT8])
        mux_point_address_reg <= mux_point_address_reg + 16'h0001;
      if (LINK.cs_ack) begin
        unique case (st_r)
          ST_LOAD_WC: begin
            transfer_count_reg  <= LINK.cs_rdata[`TW_CNT_W-1:0];
            scan_action_reg     <= LINK.cs_rdata[`TW_CHAIN:`TW_NOINT];
            channel_pointer_reg <= channel_pointer_reg + 16'h0001;
          end
          ST_LOAD_MUX: begin
            mux_point_address_reg <= LINK.cs_rdata;
            channel_pointer_reg   <= channel_pointer_reg + 16'h0001;
            // Count covers the point word too, so a table stores count-1
            transfer_count_reg    <= transfer_count_reg -
                                     `TW_CNT_W'(1);
          end
          ST_FETCH: begin
            mux_point_address_reg <= LINK.cs_rdata;
            // A limit word rides behind its entry and is skipped
            mux_chan_ptr_r <= mux_chan_ptr_r +
                (LINK.cs_rdata[`MW_LIMIT] ? 16'h0002 : 16'h0001);
          end
          ST_STORE: begin
            channel_pointer_reg <= channel_pointer_reg + 16'h0001;
            transfer_count_reg  <= transfer_count_reg - `TW_CNT_W'(1);
            if (!rand_r)
              mux_point_address_reg <= mux_point_address_reg +
                                       16'h0001;
          end
          ST_CHAIN_CA: channel_pointer_reg <= LINK.cs_rdata;
          ST_CHAIN_CK: channel_pointer_reg <= channel_pointer_reg + 16'h0001;
          default: ;
        endcase
      end
    end
  end

  // Converter start pulse and result capture
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      start_r  <= 1'b0;
      result_r <= 16'h0000;
    end else begin
      start_r <= (st_r == ST_SELECT) && (!ext_r || SYNC_IN);
      if (st_r == ST_CONV && CONV_DONE)
        result_r <= {CONV_SIGN, CONV_OVER, mag_masked};
    end
  end

  // Status indicators; a new event beats a sense clear
  always_ff @(posedge MCLK) begin
    if (!RESET_N || (take && LINK.cmd_func == `FN_CONTROL)) begin
      eot_r      <= 1'b0;
      ss_done_r  <= 1'b0;
      rly_done_r <= 1'b0;
      chk_err_r  <= 1'b0;
      over_r     <= 1'b0;
    end else begin
      if (table_end && !scan_action_reg[0])
        eot_r <= 1'b1;
      else if (clr_stat)
        eot_r <= 1'b0;
      if (st_r == ST_CONV && st_nxt == ST_DPC_HOLD &&
          mux_point_address_reg[`MW_SS])
        ss_done_r <= 1'b1;
      else if (clr_stat || (take && LINK.cmd_func == `FN_READ))
        ss_done_r <= 1'b0;
      if (st_r == ST_CONV && st_nxt == ST_DPC_HOLD &&
          !mux_point_address_reg[`MW_SS])
        rly_done_r <= 1'b1;
      else if (clr_stat || (take && LINK.cmd_func == `FN_READ))
        rly_done_r <= 1'b0;
      if (st_r == ST_CHAIN_CK && LINK.cs_ack &&
          LINK.cs_rdata != channel_pointer_reg)
        chk_err_r <= 1'b1;
      else if (clr_stat)
        chk_err_r <= 1'b0;
      if (st_r == ST_CONV && CONV_DONE && CONV_OVER)
        over_r <= 1'b1;
      else if (clr_stat)
        over_r <= 1'b0;
    end
  end

  // Answers to read and sense, one cycle after acceptance
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      resp_v_r <= 1'b0;
      resp_d_r <= 16'h0000;
    end else begin
      resp_v_r <= take && (LINK.cmd_func == `FN_READ ||
                           LINK.cmd_func == `FN_SENSE);
      if (take && LINK.cmd_func == `FN_READ)
        resp_d_r <= result_r;
      else if (take && LINK.cmd_func == `FN_SENSE)
        resp_d_r <= LINK.cmd_mod[`MB_BIT8] ? mux_point_address_reg
                                           : stat_word;
    end
  end
endmodule

// ---- test/ai_scan_properties.sv ----
// Link checks between the processor end and the scan device
`timescale 1ns/1ps
`include "ai_scan_defines.svh"
module ai_scan_properties (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RESET_N,
  // Command path
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [4:0]  cmd_area,
  input wire logic [2:0]  cmd_func,
  input wire logic [15:0] cmd_word,
  input wire logic        resp_valid,
  // Cycle steal and interrupt
  input wire logic        cs_req,
  input wire logic        cs_we,
  input wire logic [15:0] cs_addr,
  input wire logic        cs_ack,
  input wire logic        irq
);
  logic take;
  // Command handed over this cycle
  assign take = cmd_valid && cmd_ready;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  a_read_answered: assert property (
    take && cmd_func inside {`FN_READ, `FN_SENSE} |=> resp_valid)
    else $error("read left unanswered");
  a_quiet_other: assert property (
    take && !(cmd_func inside {`FN_READ, `FN_SENSE}) |=> !resp_valid)
    else $error("answer without cause");
  a_area_refused: assert property (
    cmd_valid && !(cmd_area inside {`AREA_BASIC, `AREA_EXPAND})
      |-> !cmd_ready)
    else $error("foreign area taken");
  // Request must stand until granted; a blast may drop it
  a_steal_holds: assert property (
    cs_req && !cs_ack && !take
      |=> cs_req && $stable(cs_addr) && $stable(cs_we))
    else $error("steal changed early");
  a_start_fetch: assert property (
    take && cmd_func == `FN_INIT_RD
      |=> cs_req && !cs_we && cs_addr == $past(cmd_word))
    else $error("start fetch wrong");
  a_grant_single: assert property (
    cs_ack |=> !cs_ack)
    else $error("grant repeated");
  a_grant_req: assert property (
    cs_ack |-> $past(cs_req))
    else $error("grant without request");
  a_irq_clear: assert property (
    $fell(irq) |-> $past(take))
    else $error("interrupt dropped alone");
endmodule

// ---- test/tb.sv ----
// Bench: host and scan device joined over the link, converter modelled
`timescale 1ns/1ps
`include "ai_scan_defines.svh"
module tb;
  import ai_scan_pkg::*;
  logic        MCLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        MUX_SS, CONV_START, SYNC_IN, CONV_DONE, CONV_SIGN, CONV_OVER;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic [10:0] MUX_POINT, p, p2;
  logic [10:0] pts [4];
  logic [13:0] CONV_MAG;
  logic [1:0]  CONV_RES, res_exp;
  logic        e, irq_d;
  int          failures, total_checks, starts, rises, dly, i, n, m;
  ai_link_if link ();
  ai_pc_host ai_pc_host_inst (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK(link));
  ai_scan_dev ai_scan_dev_inst (.MCLK(MCLK), .RESET_N(RESET_N), .LINK(link),
    .MUX_POINT(MUX_POINT), .MUX_SS(MUX_SS), .CONV_START(CONV_START),
    .CONV_RES(CONV_RES), .SYNC_IN(SYNC_IN), .CONV_DONE(CONV_DONE),
    .CONV_SIGN(CONV_SIGN), .CONV_MAG(CONV_MAG), .CONV_OVER(CONV_OVER));
  ai_scan_properties ai_scan_properties_inst (.MCLK(MCLK),
    .RESET_N(RESET_N), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cmd_area(link.cmd_area),
    .cmd_func(link.cmd_func), .cmd_word(link.cmd_word),
    .resp_valid(link.resp_valid), .cs_req(link.cs_req),
    .cs_we(link.cs_we), .cs_addr(link.cs_addr), .cs_ack(link.cs_ack),
    .irq(link.irq));
  // 100 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // Converter result is a function of the point, so stores are checkable
  function automatic word_t conv(input logic [10:0] pt);
    return {pt[0], pt[7:0] == 8'hff, pt[7:0], 6'h00};
  endfunction
  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic give_up;
    failures++;
    end_of_test();
  endtask
  // Converter answers a few cycles after start; interrupt edges counted
  always @(posedge MCLK) begin
    CONV_DONE <= 1'b0;
    SYNC_IN <= 1'($urandom_range(1));
    irq_d <= link.irq;
    if (link.irq && !irq_d) rises <= rises + 1;
    if (CONV_START) begin
      starts <= starts + 1;
      ck(32'(CONV_RES), 32'(res_exp));
      ck(MUX_SS, 1'b1);
      {CONV_SIGN, CONV_OVER, CONV_MAG} <= conv(MUX_POINT);
      dly <= 1 + $urandom_range(3);
    end else if (dly > 0) begin
      dly <= dly - 1;
      CONV_DONE <= (dly == 1);
    end
  end
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'b1 && k < 64);
    if (k >= 64) give_up();
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Poll status until a bit reaches the wanted level
  task automatic waitst(input int b, input logic v);
    int k;
    k = 0;
    do begin
      apb(1'b0, `OFF_STAT, 32'h0);
      k++;
    end while (q[b] !== v && k < 3000);
    if (k >= 3000) give_up();
  endtask
  task automatic cmd(input logic [2:0] f, input logic [7:0] md,
                     input logic [15:0] w, input logic [4:0] ar = `AREA_BASIC);
    apb(1'b1, `OFF_CMD, {md, f, ar, w});
    waitst(0, 1'b0);
  endtask
  task automatic mw(input logic [7:0] a, input word_t d);
    apb(1'b1, `OFF_MADDR, {24'h0, a});
    apb(1'b1, `OFF_MDATA, {16'h0, d});
  endtask
  task automatic mchk(input logic [7:0] a, input word_t x);
    apb(1'b1, `OFF_MADDR, {24'h0, a});
    apb(1'b0, `OFF_MDATA, 32'h0);
    ck(q[15:0], x);
  endtask
  // Main sequence
  initial begin
    void'($urandom(25));
    {RESET_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {SYNC_IN, CONV_DONE, CONV_SIGN, CONV_OVER, CONV_MAG, irq_d} = '0;
    {res_exp, failures, total_checks, starts, rises, dly} = '0;
    repeat (8) @(posedge MCLK);
    RESET_N <= 1'b1;
    SYNC_IN <= 1'b1;
    cmd(`FN_SENSE, 8'h80, 16'h0);
    apb(1'b0, `OFF_STAT, 32'h0);
    ck(q[31:16], 16'h0);
    // Two chained tables; only the second end may interrupt
    n = 1 + $urandom_range(3);
    m = 1 + $urandom_range(3);
    p = 11'($urandom_range(200));
    p2 = 11'($urandom_range(200));
    mw(8'h20, {2'b11, 14'(n + 1)});
    mw(8'h21, {5'h02, p});
    mw(8'(8'h22 + n), 16'h0030);
    mw(8'h30, 16'h0030);
    mw(8'h31, {2'b00, 14'(m + 1)});
    mw(8'h32, {5'h02, p2});
    res_exp = 2'b10;
    cmd(`FN_INIT_RD, 8'h08, 16'h0020, `AREA_EXPAND);
    waitst(1, 1'b1);
    for (i = 0; i < n; i++) mchk(8'(8'h22 + i), conv(11'(p + i)));
    for (i = 0; i < m; i++) mchk(8'(8'h33 + i), conv(11'(p2 + i)));
    mchk(8'(8'h22 + n), 16'h0030);
    cmd(`FN_SENSE, 8'h80, 16'h0);
    apb(1'b0, `OFF_STAT, 32'h0);
    ck(q[31], 1'b1);
    ck(q[16], 1'b0);
    ck(q[1], 1'b0);
    ck(rises, 1);
    // Stepped programmed reads, last point overloaded
    p = 11'h0fd;
    res_exp = 2'b01;
    cmd(`FN_WRITE, 8'h03, {5'h02, p});
    for (i = 0; i < 3; i++) begin
      waitst(1, 1'b1);
      cmd(`FN_READ, {6'h0, 1'b1, i < 2}, 16'h0);
      apb(1'b0, `OFF_STAT, 32'h0);
      ck(q[31:16], conv(11'(p + i)));
    end
    cmd(`FN_SENSE, 8'h01, 16'h0);
    apb(1'b0, `OFF_STAT, 32'h0);
    ck(q[31:16], {5'h02, 11'(p + 2)});
    repeat (20) @(posedge MCLK);
    ck(starts, n + m + 3);
    cmd(`FN_CONTROL, 8'h0, 16'h0);
    // Random addressing, a limit word in the point table
    n = 2 + $urandom_range(2);
    for (i = 0; i < n; i++) pts[i] = 11'($urandom_range(200));
    mw(8'h40, {2'b00, 14'(n)});
    mw(8'h60, {5'h0e, pts[0]});
    mw(8'h61, 16'h7f80);
    for (i = 1; i < n; i++) mw(8'(8'h61 + i), {5'h02, pts[i]});
    res_exp = 2'b00;
    cmd(`FN_INIT_RD, 8'h04, 16'h0040);
    cmd(`FN_INIT_WR, 8'h00, 16'h0060);
    waitst(1, 1'b1);
    for (i = 0; i < n; i++) mchk(8'(8'h41 + i), conv(pts[i]));
    // Foreign area stays pending; unmapped register flagged
    cmd(`FN_CONTROL, 8'h0, 16'h0);
    apb(1'b1, `OFF_CMD, {8'h0, `FN_SENSE, 5'h0b, 16'h0});
    repeat (10) @(posedge MCLK);
    apb(1'b0, `OFF_STAT, 32'h0);
    ck(q[0], 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    ck(e, 1'b1);
    ck(q, 32'h0);
    end_of_test();
  end
endmodule
